//--- pkg/usr_pkg.sv
// Purpose: shared constants and types for the serial status/buffer register block
// Assumes: AHB-Lite register access, 32-bit words, one clock
// Notes: offsets are byte addresses of aligned words
package usr_pkg;
  localparam logic [7:0] usr_off_sta = 8'h00;
  localparam logic [7:0] usr_off_stah = 8'h04;
  localparam logic [7:0] usr_off_brg = 8'h08;
  localparam logic [7:0] usr_off_brgh = 8'h0c;
  localparam logic [7:0] usr_off_rxd = 8'h10;
  localparam logic [7:0] usr_off_txd = 8'h14;
  localparam logic [7:0] usr_off_p1 = 8'h18;
  localparam logic [7:0] usr_off_ctl = 8'h1c;
  localparam int usr_depth = 8;
  localparam int usr_ptr_w = 3;
  localparam int usr_cnt_w = 4;
  localparam logic [3:0] usr_cnt_full = 4'h8;
  // status low bit positions
  localparam int usr_b_parity_or_address_flag = 6;
  localparam int usr_b_abd = 5;
  localparam int usr_b_cer = 4;
  localparam int usr_b_fer = 3;
  localparam int usr_b_brk = 2;
  localparam int usr_b_oer = 1;
  localparam int usr_b_txc = 0;
  localparam int usr_b_perie = 14;
  localparam int usr_b_ferie = 11;
  // status high bit positions, and the transmit port last-byte bit
  localparam int usr_b_tx_write_error_flag = 7;
  localparam int usr_b_stop_detect_timing = 6;
  localparam int usr_b_txbe = 5;
  localparam int usr_b_rxbe = 1;
  localparam int usr_b_txsel = 12;
  localparam int usr_b_rxsel = 8;
  localparam int usr_b_last = 15;
  // control register bits
  localparam int usr_b_txen = 0;
  localparam int usr_b_rxen = 1;
  localparam int usr_b_mode = 4;
  localparam int usr_b_flo = 8;
  localparam int usr_b_p2z = 12;
  localparam logic [3:0] usr_mode_8n = 4'h0;
  localparam logic [3:0] usr_mode_odd = 4'h2;
  localparam logic [3:0] usr_mode_even = 4'h3;
  localparam logic [3:0] usr_mode_addr = 4'h4;
  localparam logic [3:0] usr_mode_lin_r = 4'hb;
  localparam logic [3:0] usr_mode_lin_c = 4'hc;
  localparam logic [3:0] usr_mode_sc = 4'hf;
  localparam logic [1:0] usr_flo_sw = 2'h1;
  localparam logic [7:0] usr_xon_char = 8'h11;
  localparam logic [7:0] usr_xoff_char = 8'h13;
  localparam logic [8:0] usr_addr_bit = 9'h100;
  localparam logic [31:0] usr_sta_wmask = 32'h0000ff37;
  localparam logic [31:0] usr_stah_wmask = 32'h00007740;
  localparam logic [1:0] usr_htrans_nonseq = 2'h2;
  localparam logic [1:0] usr_htrans_seq = 2'h3;

  // received character with its framing bit
  typedef struct packed {
    logic frame_err;
    logic [7:0] ch;
  } usr_rx_word_t;

  // events from the line-side receiver and transmitter
  typedef struct packed {
    logic rx_valid;
    usr_rx_word_t rx_word;
    logic parity_err;
    logic addr_rcvd;
    logic autobaud_roll;
    logic chk_err;
    logic brk;
    logic tx_echo_valid;
    logic [8:0] tx_sent;
    logic [8:0] rx_echo;
    logic rx_busy;
    logic rx_stop_mid;
    logic rx_stop_end;
  } usr_line_ev_t;
endpackage : usr_pkg

//--- rtl/usr_regs.sv
// Purpose: status, buffer, baud divisor and parameter registers of a serial port
// Assumes: line-side shifter is outside; events arrive on core_clk as one-cycle pulses
// Notes: AHB-Lite slave, zero wait states, always OKAY
//
// Contract
// - status bit 6 flags parity error, or address received in address mode
// - autobaud rollover sets a sticky flag that software clears
// - checksum mismatch sets a sticky flag until software clears it
// - framing flag is stored per character and shows head of receive buffer
// - break on receive line sets a sticky flag software clears
// - character arriving at full receive buffer sets sticky overflow flag
// - transmitted word differing from read-back sets sticky collision flag
// - transmit interrupt when free slots reach eight minus select code
// - receive interrupt when buffered words reach select code plus one
// - receive watermark suppressed while enabled parity or framing error stands
// - write error flag on full buffer, zero param two, or full param one
// - writes to transmit port while buffer full are discarded
// - stop detect mode picks end-of-stop or mid-stop receive interrupt timing
// - writing one to empty bit while disabled resets that buffer's pointers
// - read-only empty and full bits; after reset empty and not full
// - receive idle bit reads one while line idle
// - under software flow control XON sets and XOFF clears flow-on bit
// - baud divisor is 20 bits split over two registers
// - receive port gives 8-bit character; transmit bit 15 marks last byte
// - address-detect transmit sends param one with ninth bit forced one
// - param one holds 6-bit identifier or 9-bit guard time by mode
//
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module usr_regs
  import usr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire usr_line_ev_t line_ev,
  input wire logic tx_pop,
  output logic tx_valid,
  output logic [8:0] tx_word,
  output logic tx_last,
  output logic addr_valid,
  output logic [8:0] addr_word,
  input wire logic addr_pop,
  output logic [19:0] baud_divisor,
  output logic [8:0] mode_param_one,
  output logic tx_irq,
  output logic rx_interrupt
);
  logic wr_pend_ff;
  logic rd_pend_ff;
  logic [7:0] addr_ff;
  logic [31:0] hrdata_ff;
  logic [15:0] sta_ctl_ff;
  logic [6:0] sta_flags_ff;
  logic [2:0] tx_irq_threshold_sel, rx_irq_threshold_sel;
  logic [2:0] txsel_ff, rxsel_ff;
  logic tx_write_error_flag;
  logic tx_write_error_flag_ff, stop_detect_timing_ff, flow_on_ff, idle_ff;
  logic [19:0] brg_ff;
  logic [8:0] p1_ff;
  logic p1_full_ff;
  logic [15:0] ctl_ff;
  usr_rx_word_t rx_mem [usr_depth];
  logic [8:0] tx_mem [usr_depth];
  logic tx_last_mem [usr_depth];
  logic [usr_ptr_w-1:0] rx_wp_ff, rx_rp_ff, tx_wp_ff, tx_rp_ff;
  logic [usr_cnt_w-1:0] rx_cnt_ff, tx_cnt_ff;
  logic tx_enable_bit, rx_enable_bit;
  logic [3:0] mode;
  logic [1:0] flow_control_select;
  logic lin_par, addr_mode;
  logic wr_acc, rd_acc, bus_go;
  logic wr_sta, wr_stah, wr_brg, wr_brgh, wr_txd, wr_p1, wr_ctl;
  logic rx_pop, rx_push, tx_push;
  logic rx_buffer_empty, rx_buffer_full, tx_buffer_empty, tx_buffer_full;
  logic framing_error_flag;
  logic rx_flush, tx_flush;
  logic [3:0] tx_free;
  logic rx_evt;
  logic [15:0] stah_rd, sta_rd;
  logic [31:0] rd_mux;

  assign tx_enable_bit = ctl_ff[usr_b_txen];
  assign rx_enable_bit = ctl_ff[usr_b_rxen];
  assign mode = ctl_ff[usr_b_mode +: 4];
  assign flow_control_select = ctl_ff[usr_b_flo +: 2];
  assign lin_par = (mode == usr_mode_odd) || (mode == usr_mode_even) ||
                   (mode == usr_mode_lin_r) || (mode == usr_mode_lin_c);
  assign addr_mode = (mode == usr_mode_addr);
  assign tx_irq_threshold_sel = txsel_ff;
  assign rx_irq_threshold_sel = rxsel_ff;
  assign tx_write_error_flag = tx_write_error_flag_ff;

  // bus address phase, data phase one cycle later
  assign bus_go = hsel && hready && (htrans == usr_htrans_nonseq || htrans == usr_htrans_seq);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= bus_go && hwrite;
      rd_pend_ff <= bus_go && !hwrite;
      addr_ff <= bus_go ? haddr : addr_ff;
    end
  end

  assign wr_acc = wr_pend_ff;
  assign rd_acc = bus_go && !hwrite;
  assign wr_sta = wr_acc && addr_ff == usr_off_sta;
  assign wr_stah = wr_acc && addr_ff == usr_off_stah;
  assign wr_brg = wr_acc && addr_ff == usr_off_brg;
  assign wr_brgh = wr_acc && addr_ff == usr_off_brgh;
  assign wr_txd = wr_acc && addr_ff == usr_off_txd;
  assign wr_p1 = wr_acc && addr_ff == usr_off_p1;
  assign wr_ctl = wr_acc && addr_ff == usr_off_ctl;

  // buffer state
  assign rx_buffer_empty = (rx_cnt_ff == '0);
  assign rx_buffer_full = (rx_cnt_ff == usr_cnt_full);
  assign tx_buffer_empty = (tx_cnt_ff == '0);
  assign tx_buffer_full = (tx_cnt_ff == usr_cnt_full);
  assign rx_pop = rd_acc && haddr == usr_off_rxd && !rx_buffer_empty;
  assign rx_push = line_ev.rx_valid && !rx_buffer_full;
  assign tx_push = wr_txd && !tx_buffer_full;
  assign rx_flush = wr_stah && hwdata[usr_b_rxbe] && !rx_enable_bit;
  assign tx_flush = wr_stah && hwdata[usr_b_txbe] && !tx_enable_bit;
  assign framing_error_flag = !rx_buffer_empty && rx_mem[rx_rp_ff].frame_err;

  always_ff @(posedge core_clk) begin
    if (rx_push) begin
      rx_mem[rx_wp_ff] <= line_ev.rx_word;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || rx_flush) begin
      rx_wp_ff <= '0;
      rx_rp_ff <= '0;
      rx_cnt_ff <= '0;
    end else begin
      rx_wp_ff <= rx_push ? rx_wp_ff + 1'b1 : rx_wp_ff;
      rx_rp_ff <= rx_pop ? rx_rp_ff + 1'b1 : rx_rp_ff;
      rx_cnt_ff <= rx_cnt_ff + {3'h0, rx_push} - {3'h0, rx_pop};
    end
  end

  always_ff @(posedge core_clk) begin
    if (tx_push) begin
      tx_mem[tx_wp_ff] <= {1'b0, hwdata[7:0]};
      tx_last_mem[tx_wp_ff] <= hwdata[usr_b_last];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || tx_flush) begin
      tx_wp_ff <= '0;
      tx_rp_ff <= '0;
      tx_cnt_ff <= '0;
    end else begin
      tx_wp_ff <= tx_push ? tx_wp_ff + 1'b1 : tx_wp_ff;
      tx_rp_ff <= (tx_pop && !tx_buffer_empty) ? tx_rp_ff + 1'b1 : tx_rp_ff;
      tx_cnt_ff <= tx_cnt_ff + {3'h0, tx_push} - {3'h0, tx_pop && !tx_buffer_empty};
    end
  end

  assign tx_valid = !tx_buffer_empty && tx_enable_bit;
  assign tx_word = tx_mem[tx_rp_ff];
  assign tx_last = tx_last_mem[tx_rp_ff];

  // sticky flags: hardware set wins over a zero write
  assign rx_evt = line_ev.rx_valid;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sta_flags_ff <= '0;
      sta_ctl_ff <= '0;
    end else begin
      if (wr_sta) begin
        sta_ctl_ff <= {hwdata[15:8], 8'h00};
      end
      sta_flags_ff[usr_b_parity_or_address_flag] <= (wr_sta ? (sta_flags_ff[usr_b_parity_or_address_flag] & hwdata[usr_b_parity_or_address_flag])
        : sta_flags_ff[usr_b_parity_or_address_flag]) | (lin_par && line_ev.parity_err) | (addr_mode && line_ev.addr_rcvd);
      sta_flags_ff[usr_b_abd] <= (wr_sta ? (sta_flags_ff[usr_b_abd] & hwdata[usr_b_abd])
        : sta_flags_ff[usr_b_abd]) | line_ev.autobaud_roll;
      sta_flags_ff[usr_b_cer] <= (wr_sta ? (sta_flags_ff[usr_b_cer] & hwdata[usr_b_cer])
        : sta_flags_ff[usr_b_cer]) | line_ev.chk_err;
      sta_flags_ff[usr_b_fer] <= 1'b0;
      sta_flags_ff[usr_b_brk] <= (wr_sta ? (sta_flags_ff[usr_b_brk] & hwdata[usr_b_brk])
        : sta_flags_ff[usr_b_brk]) | line_ev.brk;
      sta_flags_ff[usr_b_oer] <= (wr_sta ? (sta_flags_ff[usr_b_oer] & hwdata[usr_b_oer])
        : sta_flags_ff[usr_b_oer]) | (rx_evt && !rx_push);
      sta_flags_ff[usr_b_txc] <= (wr_sta ? (sta_flags_ff[usr_b_txc] & hwdata[usr_b_txc])
        : sta_flags_ff[usr_b_txc]) |
        (line_ev.tx_echo_valid && line_ev.tx_sent != line_ev.rx_echo);
    end
  end

  // status high: selects, write error, idle and flow state
  always_ff @(posedge core_clk) begin
    if (rst) begin
      txsel_ff <= '0;
      rxsel_ff <= '0;
      stop_detect_timing_ff <= 1'b0;
      tx_write_error_flag_ff <= 1'b0;
    end else begin
      if (wr_stah) begin
        txsel_ff <= hwdata[usr_b_txsel +: 3];
        rxsel_ff <= hwdata[usr_b_rxsel +: 3];
        stop_detect_timing_ff <= hwdata[usr_b_stop_detect_timing];
      end
      tx_write_error_flag_ff <= (wr_stah ? (tx_write_error_flag_ff & hwdata[usr_b_tx_write_error_flag]) : tx_write_error_flag_ff) |
        (wr_txd && (tx_buffer_full || (lin_par && ctl_ff[usr_b_p2z]))) |
        (wr_p1 && addr_mode && p1_full_ff);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      idle_ff <= 1'b1;
      flow_on_ff <= 1'b0;
    end else begin
      idle_ff <= !line_ev.rx_busy;
      if (flow_control_select == usr_flo_sw && rx_push) begin
        if (line_ev.rx_word.ch == usr_xon_char) begin
          flow_on_ff <= 1'b1;
        end else if (line_ev.rx_word.ch == usr_xoff_char) begin
          flow_on_ff <= 1'b0;
        end
      end
    end
  end

  // baud divisor, param one, control
  always_ff @(posedge core_clk) begin
    if (rst) begin
      brg_ff <= '0;
      p1_ff <= '0;
      p1_full_ff <= 1'b0;
      ctl_ff <= '0;
    end else begin
      if (wr_brg) begin
        brg_ff[15:0] <= hwdata[15:0];
      end
      if (wr_brgh) begin
        brg_ff[19:16] <= hwdata[3:0];
      end
      if (wr_ctl) begin
        ctl_ff <= hwdata[15:0];
      end
      if (wr_p1 && !(addr_mode && p1_full_ff)) begin
        p1_ff <= hwdata[8:0];
        p1_full_ff <= addr_mode;
      end else if (addr_pop) begin
        p1_full_ff <= 1'b0;
      end
    end
  end

  assign baud_divisor = brg_ff;
  assign mode_param_one = (mode == usr_mode_lin_c) ? {3'h0, p1_ff[5:0]} : p1_ff;
  assign addr_valid = addr_mode && p1_full_ff && tx_enable_bit;
  assign addr_word = {1'b0, p1_ff[7:0]} | usr_addr_bit;

  // watermark interrupts
  assign tx_free = usr_cnt_full - tx_cnt_ff;
  assign tx_irq = tx_free >= (usr_cnt_full - {1'b0, tx_irq_threshold_sel});
  logic rx_mark;
  logic rx_stop_ok;
  assign rx_stop_ok = stop_detect_timing_ff ? line_ev.rx_stop_end : line_ev.rx_stop_mid;
  assign rx_mark = (rx_cnt_ff >= ({1'b0, rx_irq_threshold_sel} + 4'h1)) && !line_ev.rx_busy
    || (rx_cnt_ff >= ({1'b0, rx_irq_threshold_sel} + 4'h1)) && rx_stop_ok;
  assign rx_interrupt = rx_mark &&
    !(sta_flags_ff[usr_b_parity_or_address_flag] && sta_ctl_ff[usr_b_perie]) &&
    !(framing_error_flag && sta_ctl_ff[usr_b_ferie]);

  // read data
  assign sta_rd = {sta_ctl_ff[15:8], 1'b0, sta_flags_ff[6:4], framing_error_flag,
                   sta_flags_ff[2:0]};
  assign stah_rd = {1'b0, txsel_ff, 1'b0, rxsel_ff, tx_write_error_flag, stop_detect_timing_ff, tx_buffer_empty,
                    tx_buffer_full, idle_ff, flow_on_ff, rx_buffer_empty, rx_buffer_full};
  always_comb begin
    rd_mux = 32'h00000000;
    case (haddr)
      usr_off_sta: rd_mux = {16'h0000, sta_rd};
      usr_off_stah: rd_mux = {16'h0000, stah_rd};
      usr_off_brg: rd_mux = {16'h0000, brg_ff[15:0]};
      usr_off_brgh: rd_mux = {28'h0000000, brg_ff[19:16]};
      usr_off_rxd: rd_mux = {24'h000000, rx_mem[rx_rp_ff].ch};
      usr_off_p1: rd_mux = {23'h000000, p1_ff};
      usr_off_ctl: rd_mux = {16'h0000, ctl_ff};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hrdata_ff <= '0;
    end else if (rd_acc) begin
      hrdata_ff <= rd_mux;
    end
  end
endmodule : usr_regs

//--- sim/usr_regs_asserts.sv
// Purpose: port timing checks for the serial register block
// Assumes: zero wait state slave, writes land at the end of the data phase
// Notes: wd_ff holds the offset written at the last edge
`timescale 1ns/1ps
module usr_regs_asserts
  import usr_pkg::*;
(
  input logic core_clk,
  input logic rst,
  input logic hsel,
  input logic [7:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  input logic [31:0] hrdata,
  input logic hreadyout,
  input logic hresp,
  input usr_line_ev_t line_ev,
  input logic tx_pop,
  input logic tx_valid,
  input logic [8:0] tx_word,
  input logic tx_last,
  input logic addr_valid,
  input logic [8:0] addr_word,
  input logic addr_pop,
  input logic [19:0] baud_divisor,
  input logic [8:0] mode_param_one,
  input logic tx_irq,
  input logic rx_interrupt
);
  logic wr_ff;
  logic [7:0] wa_ff;
  logic [7:0] wd_ff;
  logic aph;
  assign aph = hsel && hready && htrans[1];
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ff <= 1'b0;
      wd_ff <= 8'hff;
    end else begin
      wr_ff <= aph && hwrite;
      wd_ff <= wr_ff ? wa_ff : 8'hff;
    end
  end
  always_ff @(posedge core_clk) begin
    wa_ff <= haddr;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  addr_word_a: assert property (addr_valid |-> addr_word == {1'b1, mode_param_one[7:0]})
    else $error("address word wrong");
  divisor_hold_a: assert property (!$stable(baud_divisor) |->
    wd_ff == usr_off_brg || wd_ff == usr_off_brgh) else $error("divisor changed unwritten");
  param_hold_a: assert property (!$stable(mode_param_one) |->
    wd_ff == usr_off_p1 || wd_ff == usr_off_ctl) else $error("param one changed unwritten");
  tx_stop_a: assert property ($fell(tx_valid) |-> $past(tx_pop) ||
    wd_ff == usr_off_ctl || wd_ff == usr_off_stah) else $error("tx data lost");
  head_hold_a: assert property (tx_valid && !tx_pop ##1 tx_valid |->
    $stable(tx_word) && $stable(tx_last)) else $error("tx head changed");
  irq_reset_a: assert property ($fell(rst) |-> tx_irq && !rx_interrupt)
    else $error("irq levels wrong after reset");
  rx_rise_a: assert property ($rose(rx_interrupt) |-> $past(line_ev.rx_valid) ||
    $past(aph) || $past(wr_ff) || line_ev.rx_stop_mid || line_ev.rx_stop_end ||
    $fell(line_ev.rx_busy)) else $error("rx irq without cause");
  cover property (tx_pop && tx_last);
  cover property ($rose(rx_interrupt));
  cover property (tx_irq ##1 !tx_irq);
endmodule : usr_regs_asserts
bind usr_regs usr_regs_asserts u_chk (.*);

//--- sim/usr_line_model.sv
// Purpose: remote serial node driving line events and draining the tx buffer
// Assumes: one frame every two core_clk cycles
// Notes: collide makes the read-back differ from the sent word
`timescale 1ns/1ps
module usr_line_model
  import usr_pkg::*;
(
  input logic core_clk,
  input logic tx_valid,
  input logic [8:0] tx_word,
  output usr_line_ev_t line_ev,
  output logic tx_pop
);
  usr_line_ev_t ev_q = '0;
  usr_line_ev_t echo_q = '0;
  logic collide = 1'b0;
  initial tx_pop = 1'b0;
  assign line_ev = ev_q | echo_q;
  always @(posedge core_clk) begin : drain
    usr_line_ev_t e;
    e = '0;
    e.tx_echo_valid = tx_valid && !tx_pop;
    e.tx_sent = tx_word;
    e.rx_echo = tx_word ^ {8'h00, collide};
    tx_pop <= e.tx_echo_valid;
    echo_q <= e;
  end
  // idle data shows the inverse of the last character
  task automatic pulse(input usr_line_ev_t ev);
    usr_line_ev_t idle;
    idle = '0;
    idle.rx_word = ~ev.rx_word;
    @(posedge core_clk);
    ev_q <= ev;
    @(posedge core_clk);
    ev_q <= idle;
    #1;
  endtask : pulse
endmodule : usr_line_model

//--- sim/usr_regs_test.sv
// Purpose: self-checking bench for the serial register block
// Assumes: AHB-Lite single word transfers, line node model on the far side
// Notes: checks follow each bus transfer once outputs settle
`timescale 1ns/1ps
module usr_regs_test;
  import usr_pkg::*;
  logic core_clk = 0, rst = 1, hsel = 1, hwrite = 0;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [31:0] hwdata = 0, hrdata, q;
  logic hreadyout, hresp, tx_pop, tx_valid, tx_last, addr_valid, tx_irq, rx_interrupt;
  logic [8:0] tx_word, addr_word, mode_param_one;
  logic [19:0] baud_divisor;
  usr_line_ev_t line_ev;
  int fails = 0, comparisons = 0;
  logic [8:0] seen[$];
  always #25 core_clk = ~core_clk;
  usr_regs dut (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .line_ev, .tx_pop, .tx_valid, .tx_word,
    .tx_last, .addr_valid, .addr_word, .addr_pop(1'b0), .baud_divisor, .mode_param_one,
    .tx_irq, .rx_interrupt);
  usr_line_model node (.core_clk, .tx_valid, .tx_word, .line_ev, .tx_pop);
  always @(posedge core_clk) if (tx_pop && tx_valid) seen.push_back({tx_last, tx_word[7:0]});
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("unexpected %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    haddr <= a;
    hwrite <= w;
    htrans <= usr_htrans_nonseq;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
    #1;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic rxc(input logic [7:0] ch, input logic fe);
    usr_line_ev_t e;
    e = '0;
    e.rx_valid = 1'b1;
    e.rx_word = {fe, ch};
    node.pulse(e);
  endtask : rxc
  task automatic t_reset;
    rd(usr_off_stah);
    chk(q & 32'hfffb, 32'h2a);
    chk(tx_irq, 1);
    chk(rx_interrupt, 0);
    rd(8'h20);
    chk(q, 0);
    wr(usr_off_brg, 32'h1234a5c3);
    wr(usr_off_brgh, 32'hfff7);
    chk(baud_divisor, 20'h7a5c3);
    rd(usr_off_brgh);
    chk(q, 32'h7);
  endtask : t_reset
  task automatic t_tx;
    int n;
    for (int k = 0; k < 9; k++) begin
      if (k == 4) for (int c = 0; c < 8; c++) begin
        wr(usr_off_stah, c << usr_b_txsel);
        chk(tx_irq, c >= 4);
      end
      wr(usr_off_txd, 32'h40 + k + (32'(k == 7) << usr_b_last));
    end
    rd(usr_off_stah);
    chk(q & 32'hb0, 32'h90);
    chk(tx_irq, 0);
    node.collide = 1'b1;
    wr(usr_off_ctl, 32'h1);
    for (n = 0; n < 60 && tx_valid !== 1'b0; n++) @(posedge core_clk);
    chk(tx_valid, 0);
    chk(seen.size(), 8);
    for (int k = 0; k < 8; k++) chk(seen[k], (32'(k == 7) << 8) + 32'h40 + k);
    rd(usr_off_sta);
    chk(q[usr_b_txc], 1);
    wr(usr_off_stah, 32'h0);
    wr(usr_off_sta, 32'h0);
    rd(usr_off_stah);
    chk(q & 32'hb0, 32'h20);
    rd(usr_off_sta);
    chk(q[usr_b_txc], 0);
  endtask : t_tx
  task automatic t_rx;
    wr(usr_off_ctl, 32'h3);
    wr(usr_off_stah, 32'h7 << usr_b_rxsel);
    for (int k = 0; k < 9; k++) begin
      chk(rx_interrupt, k == 8);
      rxc(8'h60 + k, !k[0]);
    end
    rd(usr_off_stah);
    chk(q & 32'h3, 32'h1);
    // checksum is not relied on after this overflow
    rd(usr_off_sta);
    chk(q & 32'ha, 32'ha);
    wr(usr_off_sta, 32'h802);
    chk(rx_interrupt, 0);
    wr(usr_off_sta, 32'h2);
    chk(rx_interrupt, 1);
    for (int k = 0; k < 8; k++) begin
      rd(usr_off_sta);
      chk(q[usr_b_fer], !k[0]);
      rd(usr_off_rxd);
      chk(q, 32'h60 + k);
    end
    rxc(8'h55, 1'b0);
    rd(usr_off_stah);
    chk(q & 32'h3, 32'h0);
    wr(usr_off_ctl, 32'h1);
    wr(usr_off_stah, 32'h2);
    rd(usr_off_stah);
    chk(q & 32'h3, 32'h2);
  endtask : t_rx
  task automatic t_flags;
    usr_line_ev_t e;
    int b;
    wr(usr_off_ctl, 32'h102);
    rxc(usr_xon_char, 1'b0);
    rd(usr_off_stah);
    chk(q & 32'h4, 32'h4);
    rxc(usr_xoff_char, 1'b0);
    rd(usr_off_stah);
    chk(q & 32'h4, 32'h0);
    wr(usr_off_ctl, 32'h20);
    wr(usr_off_sta, 32'h0);
    for (int i = 0; i < 4; i++) begin
      e = '0;
      case (i)
        0: begin e.parity_err = 1'b1; b = usr_b_parity_or_address_flag; end
        1: begin e.autobaud_roll = 1'b1; b = usr_b_abd; end
        2: begin e.chk_err = 1'b1; b = usr_b_cer; end
        default: begin e.brk = 1'b1; b = usr_b_brk; end
      endcase
      node.pulse(e);
      rd(usr_off_sta);
      chk(q[b], 1);
    end
    wr(usr_off_sta, 32'h34);
    rd(usr_off_sta);
    chk(q & 32'h34, 32'h34);
    wr(usr_off_sta, 32'h0);
    rd(usr_off_sta);
    chk(q & 32'h34, 32'h0);
    wr(usr_off_ctl, 32'h41);
    e = '0;
    e.addr_rcvd = 1'b1;
    node.pulse(e);
    rd(usr_off_sta);
    chk(q & 32'h40, 32'h40);
    wr(usr_off_p1, 32'h05a);
    chk(addr_word, 9'h15a);
    chk(addr_valid, 1);
    wr(usr_off_p1, 32'h0a5);
    rd(usr_off_stah);
    chk(q & 32'h80, 32'h80);
    chk(addr_word, 9'h15a);
    wr(usr_off_ctl, 32'hc0);
    chk(mode_param_one, 9'h01a);
  endtask : t_flags
  task automatic stop_test;
    if (fails == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    t_reset;
    t_tx;
    t_rx;
    t_flags;
    stop_test;
  end
  initial begin
    #200000;
    fails++;
    stop_test;
  end
endmodule : usr_regs_test
